//--- rtl/isv_defines.vh
// constants for the interrupt source and vector logic
`ifndef ISV_DEFINES_VH
`define ISV_DEFINES_VH
`define ISV_OFS_CTRL 8'h00
`define ISV_OFS_SENSE 8'h04
`define ISV_OFS_ENABLE 8'h08
`define ISV_OFS_STATUS 8'h0C
`define ISV_OFS_PRIOA 8'h10
`define ISV_OFS_PRIOB 8'h14
`define ISV_OFS_PRIOC 8'h18
`define ISV_OFS_DTCEN 8'h1C
`define ISV_OFS_INTSTAT 8'h20
`define ISV_OFS_INTMASK 8'h24
`define ISV_CTRL_EDGE_BIT 0
`define ISV_CTRL_MODE_BIT 1
`define ISV_SENSE_LOW 2'b00
`define ISV_SENSE_FALL 2'b01
`define ISV_SENSE_RISE 2'b10
`define ISV_SENSE_BOTH 2'b11
`define ISV_SENSE_RESET 12'h000
`define ISV_PRIO_RESET 8'h77
`define ISV_NMI_VECTOR 8'h07
`define ISV_PIN0_VECTOR 8'h10
`define ISV_WDT_VECTOR 8'h19
`define ISV_ADC_VECTOR 8'h1C
`define ISV_TPU0_VECTOR 8'h20
`define ISV_SCI0_VECTOR 8'h50
`define ISV_NMI_LEVEL 3'h7
`define ISV_NUM_PINS 6
`define ISV_NUM_PERIPH 11
`define ISV_NUM_SRC 18
`endif

//--- rtl/isv_controller.v
// interrupt source collection, vector assignment and priority resolution
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "isv_defines.vh"

module isv_controller (
	// clock and reset
	input wire mclk,
	input wire rst,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// external pins
	input wire nmiPin,
	input wire [5:0] extRequestPins,
	// on-chip peripheral flag and enable pairs
	input wire [10:0] periphFlag,
	input wire [10:0] periphEnable,
	// cpu side
	output reg cpuReqValid,
	output reg cpuReqNmi,
	output reg [7:0] cpuReqVector,
	output reg [15:0] cpuReqAddr,
	output reg [2:0] cpuReqLevel,
	input wire cpuAck,
	input wire [7:0] cpuAckVector,
	// transfer controller side
	output reg dtcReqValid,
	output reg [7:0] dtcReqVector,
	input wire dtcDone,
	input wire [7:0] dtcDoneVector,
	input wire transferDisableSelect,
	// standby wake and summary interrupt
	output reg wakeRequest,
	output wire irq
);

	reg [1:0] systemControlReg;
	reg [11:0] pinSenseControl;
	reg [5:0] pinRequestEnable;
	reg [5:0] pinRequestFlag;
	reg [5:0] flagReadArmed;
	reg [7:0] prioA;
	reg [7:0] prioB;
	reg [7:0] prioC;
	reg [16:0] dtcEnable;
	reg [6:0] intStatus;
	reg [6:0] intMask;
	reg nmiPend;
	reg [6:0] sync1;
	reg [6:0] sync2;
	reg [6:0] sync3;
	reg [6:0] pinStable;
	reg [6:0] pinPrev;
	wire [5:0] pinSet;
	wire [5:0] pinClr;
	wire [5:0] next_flag;
	reg [31:0] next_rdata;
	reg bestFound;
	reg [4:0] bestIdx;
	reg [2:0] bestLvl;
	reg dtcFound;
	reg [4:0] dtcIdx;
	reg [2:0] lvl;
	wire nmiEdge;
	wire [17:0] reqVec;
	wire [17:0] cpuCand;
	wire [16:0] dtcCand;
	wire apbWrite;
	wire apbRead;
	wire mapped;
	integer k;
	integer j;
	genvar g;

	// vector number of each source, in default order
	function [7:0] srcVec;
		input [4:0] idx;
		begin
			if (idx == 5'd0)
				srcVec = `ISV_NMI_VECTOR;
			else if (idx <= 5'd6)
				srcVec = `ISV_PIN0_VECTOR + {3'b000, idx} - 8'h01;
			else if (idx == 5'd7)
				srcVec = `ISV_WDT_VECTOR;
			else if (idx == 5'd8)
				srcVec = `ISV_ADC_VECTOR;
			else if (idx <= 5'd13)
				srcVec = `ISV_TPU0_VECTOR + {3'b000, idx} - 8'h09;
			else
				srcVec = `ISV_SCI0_VECTOR + {3'b000, idx} - 8'h0E;
		end
	endfunction

	// programmed level of each source; pins 2 and 3, pins 4 and 5, wdt and adc each share one field; all five tpu and four sci sources share one more
	function [2:0] srcLevel;
		input [4:0] idx;
		input [7:0] pa;
		input [7:0] pb;
		input [7:0] pc;
		begin
			case (idx)
				5'd1: srcLevel = pa[6:4];
				5'd2: srcLevel = pa[2:0];
				5'd3, 5'd4: srcLevel = pb[6:4];
				5'd5, 5'd6: srcLevel = pb[2:0];
				5'd7, 5'd8: srcLevel = pc[6:4];
				default: srcLevel = pc[2:0];
			endcase
		end
	endfunction

	assign apbWrite = psel && penable && pwrite;
	assign apbRead = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign mapped = (paddr[1:0] == 2'b00) && (paddr <= `ISV_OFS_INTMASK);
	assign pslverr = psel && penable && !mapped;

	// three-stage synchroniser; only an agreed level is taken
	always @(posedge mclk)
	begin
		if (rst)
		begin
			sync1 <= 7'h7F;
			sync2 <= 7'h7F;
			sync3 <= 7'h7F;
			pinStable <= 7'h7F;
			pinPrev <= 7'h7F;
		end
		else
		begin
			sync1 <= {extRequestPins, nmiPin};
			sync2 <= sync1;
			sync3 <= sync2;
			// a bit moves only where stages two and three agree
			pinStable <= (pinStable & (sync2 ^ sync3)) | (sync3 & ~(sync2 ^ sync3));
			pinPrev <= pinStable;
		end
	end

	assign nmiEdge = systemControlReg[`ISV_CTRL_EDGE_BIT] ? (pinStable[0] && !pinPrev[0]) :
		(!pinStable[0] && pinPrev[0]);

	// does the selected sense condition hold for one pin
	function senseHit;
		input [1:0] code;
		input prevLvl;
		input nowLvl;
		begin
			case (code)
				`ISV_SENSE_LOW: senseHit = !nowLvl;
				`ISV_SENSE_FALL: senseHit = prevLvl && !nowLvl;
				`ISV_SENSE_RISE: senseHit = !prevLvl && nowLvl;
				default: senseHit = prevLvl ^ nowLvl;
			endcase
		end
	endfunction

	// handler address word: vector number times four, low 16 bits
	function [15:0] vecAddr;
		input [7:0] vec;
		begin
			vecAddr = {6'b00_0000, vec, 2'b00};
		end
	endfunction

	// per-pin flag set and clear terms
	generate
		for (g = 0; g < `ISV_NUM_PINS; g = g + 1)
		begin : gPinFlag
			// source index of this pin in default order
			localparam [4:0] srcIdx = g + 1;
			wire swClear;
			wire cpuClear;
			wire dtcClear;
			assign pinSet[g] = senseHit(pinSenseControl[2*g +: 2], pinPrev[g+1], pinStable[g+1]);
			// software clear needs an earlier read of one
			assign swClear = apbWrite && (paddr == `ISV_OFS_STATUS) && !pwdata[g] && flagReadArmed[g];
			// level sense clears on cpu handling only once the pin is high
			assign cpuClear = cpuAck && (cpuAckVector == srcVec(srcIdx)) &&
				((pinSenseControl[2*g +: 2] != `ISV_SENSE_LOW) || pinStable[g+1]);
			assign dtcClear = dtcDone && (dtcDoneVector == srcVec(srcIdx)) && !transferDisableSelect;
			assign pinClr[g] = swClear || cpuClear || dtcClear;
			// set wins, so an event in the clear cycle is never lost
			assign next_flag[g] = pinSet[g] || (pinRequestFlag[g] && !pinClr[g]);
		end
	endgenerate

	// request vector in default order: nmi, pins, peripherals
	assign reqVec = {periphFlag & periphEnable, pinRequestFlag & pinRequestEnable, nmiPend};
	assign cpuCand = reqVec & ~{dtcEnable, 1'b0};
	assign dtcCand = reqVec[17:1] & dtcEnable;

	// arbitration: higher level wins, ascending scan keeps lower vector on a tie
	always @*
	begin
		bestFound = 1'b0;
		bestIdx = 5'd0;
		bestLvl = 3'd0;
		lvl = 3'd0;
		for (k = 1; k < `ISV_NUM_SRC; k = k + 1)
		begin
			lvl = systemControlReg[`ISV_CTRL_MODE_BIT] ? srcLevel(k[4:0], prioA, prioB, prioC) : 3'd0;
			if (cpuCand[k] && (!bestFound || lvl > bestLvl))
			begin
				bestFound = 1'b1;
				bestIdx = k[4:0];
				bestLvl = lvl;
			end
		end
		if (nmiPend)
		begin
			bestFound = 1'b1;
			bestIdx = 5'd0;
			bestLvl = `ISV_NMI_LEVEL;
		end
	end

	// transfer controller takes the lowest enabled source; no level or mask involved
	always @*
	begin
		dtcFound = 1'b0;
		dtcIdx = 5'd1;
		for (j = 1; j < `ISV_NUM_SRC; j = j + 1)
		begin
			if (dtcCand[j-1] && !dtcFound)
			begin
				dtcFound = 1'b1;
				dtcIdx = j[4:0];
			end
		end
	end

	// read data mux, captured in the setup cycle
	always @*
	begin
		case (paddr)
			`ISV_OFS_CTRL: next_rdata = {30'h0000_0000, systemControlReg};
			`ISV_OFS_SENSE: next_rdata = {20'h0_0000, pinSenseControl};
			`ISV_OFS_ENABLE: next_rdata = {26'h000_0000, pinRequestEnable};
			`ISV_OFS_STATUS: next_rdata = {26'h000_0000, pinRequestFlag};
			`ISV_OFS_PRIOA: next_rdata = {24'h00_0000, prioA};
			`ISV_OFS_PRIOB: next_rdata = {24'h00_0000, prioB};
			`ISV_OFS_PRIOC: next_rdata = {24'h00_0000, prioC};
			`ISV_OFS_DTCEN: next_rdata = {15'h0000, dtcEnable};
			`ISV_OFS_INTSTAT: next_rdata = {25'h000_0000, intStatus};
			`ISV_OFS_INTMASK: next_rdata = {25'h000_0000, intMask};
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// read data is captured in the setup cycle and stands through the access
	always @(posedge mclk)
	begin
		if (rst)
			prdata <= 32'h0000_0000;
		else if (psel && !penable)
			prdata <= next_rdata;
	end

	// flags, pending nmi and event status
	always @(posedge mclk)
	begin
		if (rst)
		begin
			pinRequestFlag <= 6'h00;
			flagReadArmed <= 6'h00;
			intStatus <= 7'h00;
			nmiPend <= 1'b0;
		end
		else
		begin
			pinRequestFlag <= next_flag;
			// a set arriving with the ack keeps nmi pending
			nmiPend <= nmiEdge || (nmiPend && !(cpuAck && cpuAckVector == `ISV_NMI_VECTOR));
			// clear of a status bit loses against a new event
			intStatus <= {pinSet & ~pinRequestFlag, nmiEdge} |
				(intStatus & ~((apbWrite && paddr == `ISV_OFS_INTSTAT) ? pwdata[6:0] : 7'h00));
			// arm only bits the captured read showed as one
			if (apbRead && paddr == `ISV_OFS_STATUS)
				flagReadArmed <= flagReadArmed | (prdata[5:0] & pinRequestFlag);
			else if (apbWrite && paddr == `ISV_OFS_STATUS)
				flagReadArmed <= flagReadArmed & pwdata[5:0];
		end
	end

	// software configuration registers
	always @(posedge mclk)
	begin
		if (rst)
		begin
			systemControlReg <= 2'b00;
			pinSenseControl <= `ISV_SENSE_RESET;
			pinRequestEnable <= 6'h00;
			prioA <= `ISV_PRIO_RESET;
			prioB <= `ISV_PRIO_RESET;
			prioC <= `ISV_PRIO_RESET;
			dtcEnable <= 17'h0_0000;
			intMask <= 7'h00;
		end
		else
		begin
			if (apbWrite)
			begin
				case (paddr)
					`ISV_OFS_CTRL: systemControlReg <= pwdata[1:0];
					`ISV_OFS_SENSE: pinSenseControl <= pwdata[11:0];
					`ISV_OFS_ENABLE: pinRequestEnable <= pwdata[5:0];
					`ISV_OFS_PRIOA: prioA <= pwdata[7:0] & 8'h77;
					`ISV_OFS_PRIOB: prioB <= pwdata[7:0] & 8'h77;
					`ISV_OFS_PRIOC: prioC <= pwdata[7:0] & 8'h77;
					`ISV_OFS_DTCEN: dtcEnable <= pwdata[16:0];
					`ISV_OFS_INTMASK: intMask <= pwdata[6:0];
					default: ;
				endcase
			end
		end
	end

	// registered request outputs; one cycle behind the pending state
	always @(posedge mclk)
	begin
		if (rst)
		begin
			cpuReqValid <= 1'b0;
			cpuReqNmi <= 1'b0;
			cpuReqVector <= 8'h00;
			cpuReqAddr <= 16'h0000;
			cpuReqLevel <= 3'd0;
			dtcReqValid <= 1'b0;
			dtcReqVector <= 8'h00;
			wakeRequest <= 1'b0;
		end
		else
		begin
			cpuReqValid <= bestFound;
			cpuReqNmi <= nmiPend;
			cpuReqVector <= srcVec(bestIdx);
			cpuReqAddr <= vecAddr(srcVec(bestIdx));
			cpuReqLevel <= bestLvl;
			dtcReqValid <= dtcFound;
			dtcReqVector <= srcVec(dtcIdx);
			wakeRequest <= nmiPend || |(pinRequestFlag & pinRequestEnable);
		end
	end

	assign irq = |(intStatus & intMask);

endmodule // isv_controller

//--- test/isv_checker.sv
// assertions on the ports of the interrupt source and vector logic
`timescale 1ns/10ps
module isv_checker (
	// clock and reset
	input wire mclk,
	input wire rst,
	// cpu side
	input wire cpuReqValid,
	input wire cpuReqNmi,
	input wire [7:0] cpuReqVector,
	input wire [15:0] cpuReqAddr,
	input wire [2:0] cpuReqLevel,
	input wire cpuAck,
	input wire [7:0] cpuAckVector,
	// transfer side and sources
	input wire dtcReqValid,
	input wire [7:0] dtcReqVector,
	input wire [10:0] periphFlag,
	input wire [10:0] periphEnable,
	input wire wakeRequest
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_nmi_ack;
		cpuAck && cpuAckVector == 8'h07;
	endsequence
	a_nmi_vector: assert property (cpuReqNmi |-> cpuReqVector == 8'h07 && cpuReqAddr == 16'h001C)
		else $error("nmi vector wrong");
	a_nmi_level: assert property (cpuReqNmi |-> cpuReqValid && cpuReqLevel == 3'h7)
		else $error("nmi not top request");
	a_addr_four_times: assert property (cpuReqValid |-> cpuReqAddr == {6'h00, cpuReqVector, 2'b00})
		else $error("vector address not four times vector");
	a_cpu_reserved: assert property (cpuReqValid |-> !(cpuReqVector inside {8'h16, 8'h17, 8'h6F}))
		else $error("reserved vector on cpu side");
	a_dtc_reserved: assert property (dtcReqValid |-> dtcReqVector >= 8'h10 && !(dtcReqVector inside {8'h16, 8'h17, 8'h6F}))
		else $error("bad vector on transfer side");
	a_periph_qualified: assert property (cpuReqValid && cpuReqVector == 8'h19 |-> $past(periphFlag[0] && periphEnable[0]))
		else $error("peripheral request without flag and enable");
	a_wake_nmi: assert property (cpuReqNmi |-> wakeRequest)
		else $error("nmi pending without wake");
	a_nmi_ack_clear: assert property (s_nmi_ack |-> ##[1:2] !cpuReqNmi)
		else $error("nmi not cleared by handling");
endmodule // isv_checker
bind isv_controller isv_checker chk (.mclk, .rst, .cpuReqValid, .cpuReqNmi, .cpuReqVector, .cpuReqAddr,
	.cpuReqLevel, .cpuAck, .cpuAckVector, .dtcReqValid, .dtcReqVector, .periphFlag, .periphEnable, .wakeRequest);

//--- test/isv_cpu_model.sv
// far side model: cpu core and transfer controller taking requests
`timescale 1ns/10ps
module isv_cpu_model (
	// clock and reset
	input wire mclk,
	input wire rst,
	// bench control: acknowledge or stall
	input wire ackOn,
	// requests
	input wire cpuReqValid,
	input wire [7:0] cpuReqVector,
	input wire dtcReqValid,
	input wire [7:0] dtcReqVector,
	// answers
	output reg cpuAck,
	output reg [7:0] cpuAckVector,
	output reg dtcDone,
	output reg [7:0] dtcDoneVector
);
	reg [2:0] gap;
	always @(posedge mclk)
	begin
		cpuAck <= 1'b0;
		dtcDone <= 1'b0;
		// vectors not held outside a pulse
		cpuAckVector <= ~cpuAckVector;
		dtcDoneVector <= ~dtcDoneVector;
		if (rst)
		begin
			gap <= 3'd0;
			cpuAckVector <= 8'h00;
			dtcDoneVector <= 8'h00;
		end
		else if (gap != 3'd0)
			gap <= gap - 3'd1;
		else if (ackOn && cpuReqValid)
		begin
			cpuAck <= 1'b1;
			cpuAckVector <= cpuReqVector;
			gap <= 3'd4;
		end
		else if (ackOn && dtcReqValid)
		begin
			dtcDone <= 1'b1;
			dtcDoneVector <= dtcReqVector;
			gap <= 3'd4;
		end
	end
endmodule // isv_cpu_model

//--- test/isv_controller_test.sv
// self-checking bench for the interrupt source and vector logic
`timescale 1ns/10ps
`include "isv_defines.vh"
module isv_controller_test;
	reg mclk = 1'b0;
	reg rst = 1'b1;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0000_0000;
	reg nmiPin = 1'b1;
	reg [5:0] pins = 6'h3F;
	reg [10:0] pFlag = 11'h000;
	reg [10:0] pEn = 11'h000;
	reg ackOn = 1'b0;
	reg disSel = 1'b0;
	reg [31:0] rdata, perr;
	int n_errors = 0;
	int checked = 0;
	int cyc = 0;
	wire [31:0] prdata;
	wire [15:0] cAddr;
	wire [7:0] cVec, aVec, dVec, ddVec;
	wire [2:0] cLvl;
	wire pready, pslverr, cValid, cNmi, cAck, dValid, dDone, wake, irq;
	always #2.5 mclk = ~mclk;
	isv_controller uut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .nmiPin(nmiPin),
		.extRequestPins(pins), .periphFlag(pFlag), .periphEnable(pEn), .cpuReqValid(cValid), .cpuReqNmi(cNmi),
		.cpuReqVector(cVec), .cpuReqAddr(cAddr), .cpuReqLevel(cLvl), .cpuAck(cAck), .cpuAckVector(aVec),
		.dtcReqValid(dValid), .dtcReqVector(dVec), .dtcDone(dDone), .dtcDoneVector(ddVec),
		.transferDisableSelect(disSel), .wakeRequest(wake), .irq(irq));
	isv_cpu_model partner (.mclk(mclk), .rst(rst), .ackOn(ackOn), .cpuReqValid(cValid), .cpuReqVector(cVec),
		.dtcReqValid(dValid), .dtcReqVector(dVec), .cpuAck(cAck), .cpuAckVector(aVec), .dtcDone(dDone),
		.dtcDoneVector(ddVec));
	task print_verdict;
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			n_errors++;
			print_verdict;
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
			n_errors++;
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// one apb transfer, held until pready is seen at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rdata = prdata;
		perr = {31'h0, pslverr};
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdata, e);
	endtask
	task t_regs;
		rd(`ISV_OFS_SENSE, 32'h0000_0000);
		rd(`ISV_OFS_PRIOA, 32'h0000_0077);
		rd(8'h40, 32'h0000_0000);
		chk(perr, 32'h0000_0001);
	endtask
	// each sense code on pin 0, flag read and then cleared by software
	task t_sense;
		for (int m = 0; m < 4; m++)
		begin
			apb(1'b1, `ISV_OFS_SENSE, m);
			wt(8);
			apb(1'b0, `ISV_OFS_STATUS, 0);
			apb(1'b1, `ISV_OFS_STATUS, 0);
			pins[0] <= 1'b0;
			wt(8);
			// zero written with no earlier read of one must not clear
			apb(1'b1, `ISV_OFS_STATUS, 0);
			rd(`ISV_OFS_STATUS, {31'h0, m != 2});
			pins[0] <= 1'b1;
			wt(8);
			rd(`ISV_OFS_STATUS, 32'h0000_0001);
			apb(1'b1, `ISV_OFS_STATUS, 1);
			rd(`ISV_OFS_STATUS, 32'h0000_0001);
			apb(1'b1, `ISV_OFS_STATUS, 0);
			rd(`ISV_OFS_STATUS, 32'h0000_0000);
		end
	endtask
	task t_enable;
		apb(1'b1, `ISV_OFS_SENSE, 1);
		apb(1'b1, `ISV_OFS_INTMASK, 2);
		pins[0] <= 1'b0;
		wt(8);
		chk(cValid, 0);
		chk(irq, 1);
		apb(1'b1, `ISV_OFS_INTSTAT, 2);
		chk(irq, 0);
		apb(1'b1, `ISV_OFS_ENABLE, 1);
		wt(2);
		chk({cValid, cVec, cAddr}, {1'b1, 8'h10, 16'h0040});
		ackOn <= 1'b1;
		wt(8);
		rd(`ISV_OFS_STATUS, 32'h0000_0000);
		chk(cValid, 0);
		ackOn <= 1'b0;
		pins[0] <= 1'b1;
	endtask
	task t_nmi;
		apb(1'b1, `ISV_OFS_CTRL, 1);
		nmiPin <= 1'b0;
		wt(8);
		chk(cNmi, 0);
		nmiPin <= 1'b1;
		wt(8);
		chk({cNmi, cAddr, wake}, {1'b1, 16'h001C, 1'b1});
		ackOn <= 1'b1;
		wt(6);
		chk(cNmi, 0);
		ackOn <= 1'b0;
	endtask
	task t_prio;
		apb(1'b1, `ISV_OFS_SENSE, 32'h0000_0041);
		apb(1'b1, `ISV_OFS_ENABLE, 9);
		pins <= 6'h36;
		wt(8);
		chk({cVec, cLvl}, {8'h10, 3'h0});
		apb(1'b1, `ISV_OFS_PRIOA, 32'h0000_0010);
		apb(1'b1, `ISV_OFS_PRIOB, 32'h0000_0070);
		apb(1'b1, `ISV_OFS_CTRL, 3);
		wt(2);
		chk({cVec, cLvl}, {8'h13, 3'h7});
		pins <= 6'h3F;
		ackOn <= 1'b1;
		wt(14);
		chk(cValid, 0);
		ackOn <= 1'b0;
		apb(1'b1, `ISV_OFS_ENABLE, 0);
	endtask
	task t_periph;
		pFlag <= 11'h001;
		wt(3);
		chk(cValid, 0);
		pEn <= 11'h001;
		wt(3);
		chk({cValid, cVec}, {1'b1, 8'h19});
		apb(1'b1, `ISV_OFS_DTCEN, 32'h0000_0040);
		wt(2);
		chk({dValid, dVec, cValid}, {1'b1, 8'h19, 1'b0});
	endtask
	// pin 0 routed to the transfer controller; its clear depends on disable select
	task t_dtc;
		apb(1'b1, `ISV_OFS_DTCEN, 32'h0000_0041);
		apb(1'b1, `ISV_OFS_ENABLE, 1);
		disSel <= 1'b1;
		pins[0] <= 1'b0;
		ackOn <= 1'b1;
		wt(12);
		chk({dValid, dVec}, {1'b1, 8'h10});
		rd(`ISV_OFS_STATUS, 32'h0000_0001);
		disSel <= 1'b0;
		wt(12);
		rd(`ISV_OFS_STATUS, 32'h0000_0000);
		chk(dVec, 8'h19);
		ackOn <= 1'b0;
		pins[0] <= 1'b1;
	endtask
	initial
	begin
		wt(6);
		rst <= 1'b0;
		t_regs;
		t_sense;
		t_enable;
		t_nmi;
		t_prio;
		t_periph;
		t_dtc;
		print_verdict;
	end
endmodule // isv_controller_test
